// ==== core/adc_seq_ctrl.sv ====
/*
 * Sequencing control for the 12-bit converter: register port, trigger
 * delay, acquisition and conversion timing, single and continuous runs,
 * result and compare registers, and pin digital-input disabling.
 * Assumes the analog core presents CONV_RESULT on REF_CLK and holds it
 * valid in the last conversion cycle; the register port is on REF_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic SW_START,
    input wire logic EXT_TRIG_EN,
    input wire logic EXT_TRIG,
    input wire logic AUX_SLOW,
    input wire logic [3:0] CHANNEL,
    input wire logic [11:0] CONV_RESULT,
    output logic SAMPLE_EN,
    output logic CONVERT_EN,
    output logic SLOW_MODE,
    output logic BUSY,
    output logic CONV_IRQ,
    output logic COMPARE_OUT,
    output logic FAULT_BRAKE_EN,
    input wire logic [7:0] PIN_DIN_A,
    input wire logic [7:0] PIN_DIN_B,
    output logic [7:0] PIN_READ_A,
    output logic [7:0] PIN_READ_B
);

    // Software-visible registers.
    logic [5:0] mode_ctl;            // Sampling mode control, bits 5:0.
    logic [7:0] ctl_two;             // Converter control two; bit 4 unused here.
    logic [7:0] delay_low;           // Low byte of the trigger delay count.
    logic [7:0] sample_count;        // Sample count setting.
    logic [7:0] disable_a;           // Digital disable for first pin group.
    logic [7:1] disable_b;           // Digital disable for second pin group.
    logic [11:0] compare_threshold;  // Compare threshold.
    logic [11:0] conversion_result;  // Last conversion result.
    logic compare_output;            // Comparator output after last result.
    logic half_complete_flag;        // Half of a continuous run done.
    logic full_complete_flag;        // Run or single conversion done.
    logic cmp_hit_flag;              // Comparator output rose.

    // Sequencer state.
    seq_state_e state;               // Current sequencer state.
    logic [10:0] timer;              // Down counter for the current phase.
    logic [8:0] done_count;          // Conversions finished in this run.

    // Synchronised pins.
    logic trig_sync;                 // External trigger after two flops.
    logic trig_prev;                 // Previous trigger level for edges.
    logic [7:0] din_a_sync;          // First pin group after two flops.
    logic [7:0] din_b_sync;          // Second pin group after two flops.

    // Combinational helpers.
    logic wr_hit;                    // A write this cycle.
    logic trig_edge;                 // Rising edge of the external trigger.
    logic ext_start;                 // Accepted external start request.
    logic [8:0] delay_count;         // Full nine-bit trigger delay.
    logic [2:0] acq_field;           // Acquisition field for the channel.
    logic [10:0] acq_cycles;         // Acquisition length in cycles.
    logic [10:0] conv_cycles;        // Conversion length in cycles.
    logic conv_end;                  // Last cycle of a conversion.
    logic [8:0] total_count;         // Conversions in a continuous run.
    logic [8:0] half_point;          // Conversions at the halfway point.
    logic run_last;                  // This conversion ends the run.
    logic half_hit;                  // This conversion reaches halfway.
    logic next_compare;              // Comparator value for new result.

    // Synchronise the trigger pin and the pin groups.
    adc_pin_sync #(.WIDTH(17)) pin_sync (
        .REF_CLK(REF_CLK),
        .RST(RST),
        .ASYNC_IN({EXT_TRIG, PIN_DIN_A, PIN_DIN_B}),
        .SYNC_OUT({trig_sync, din_a_sync, din_b_sync})
    );

    // Keep the last synchronised trigger level for edge detection.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sync;
        end
    end

    // Derived values for the sequencer.
    always_comb begin
        wr_hit = SFR_WR;
        trig_edge = trig_sync & ~trig_prev;
        ext_start = trig_edge & EXT_TRIG_EN;
        delay_count = {ctl_two[CTL2_DELAY8_BIT], delay_low};
        // upper channels use their own field.
        if (CHANNEL >= UPPER_CHANNEL_FIRST) begin
            acq_field = mode_ctl[MODE_ACQ_MSB:MODE_ACQ_LSB];
        end else begin
            acq_field = ctl_two[CTL2_ACQ_MSB:CTL2_ACQ_LSB];
        end
        acq_cycles = {6'h00, acq_field, 2'b00} + ACQ_BASE_CYCLES;
        // either speed bit selects slow mode.
        SLOW_MODE = AUX_SLOW | mode_ctl[MODE_SLOW_BIT];
        // conversion length follows the speed mode.
        conv_cycles = SLOW_MODE ? SLOW_CONV_CYCLES : FAST_CONV_CYCLES;
        conv_end = (state == ST_CONVERT) && (timer == 11'h000);
        // run length is setting plus one.
        total_count = {1'b0, sample_count} + 9'h001;
        half_point = total_count >> 1;
        run_last = !mode_ctl[MODE_REPEAT_BIT] || (done_count + 9'h001 == total_count);
        half_hit = mode_ctl[MODE_REPEAT_BIT] && (half_point != 9'h000)
            && (done_count + 9'h001 == half_point);
        if (ctl_two[CTL2_POLARITY_BIT]) begin
            next_compare = CONV_RESULT < compare_threshold;
        end else begin
            next_compare = CONV_RESULT >= compare_threshold;
        end
        SAMPLE_EN = (state == ST_ACQUIRE);
        CONVERT_EN = (state == ST_CONVERT);
        BUSY = (state != ST_IDLE);
    end

    // Sequencer: delay, acquire, convert, and repeat in continuous runs.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            timer <= 11'h000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (SW_START) begin
                        // Software starts are never delayed.
                        state <= ST_ACQUIRE;
                        timer <= acq_cycles - 11'h001;
                    end else if (ext_start) begin
                        if (delay_count == 9'h000) begin
                            state <= ST_ACQUIRE;
                            timer <= acq_cycles - 11'h001;
                        end else begin
                            state <= ST_DELAY;
                            timer <= {2'b00, delay_count} - 11'h001;
                        end
                    end
                end
                // triggers are ignored in every busy state.
                ST_DELAY: begin
                    if (timer == 11'h000) begin
                        state <= ST_ACQUIRE;
                        timer <= acq_cycles - 11'h001;
                    end else begin
                        timer <= timer - 11'h001;
                    end
                end
                ST_ACQUIRE: begin
                    if (timer == 11'h000) begin
                        state <= ST_CONVERT;
                        timer <= conv_cycles - 11'h001;
                    end else begin
                        timer <= timer - 11'h001;
                    end
                end
                ST_CONVERT: begin
                    if (timer != 11'h000) begin
                        timer <= timer - 11'h001;
                    end else if (run_last) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_ACQUIRE;
                        timer <= acq_cycles - 11'h001;
                    end
                end
            endcase
        end
    end

    // Count conversions within a run; the idle state clears the count.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            done_count <= 9'h000;
        end else if (state == ST_IDLE) begin
            done_count <= 9'h000;
        end else if (conv_end) begin
            done_count <= done_count + 9'h001;
        end
    end

    // result and comparator update together at conversion end.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            conversion_result <= 12'h000;
            compare_output <= 1'b0;
        end else if (conv_end) begin
            conversion_result <= CONV_RESULT;
            compare_output <= next_compare;
        end
    end

    // Interrupt pulse toward the interrupt system.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CONV_IRQ <= 1'b0;
        end else begin
            // halfway interrupt gated by its enable; at run end.
            CONV_IRQ <= conv_end && (run_last || (half_hit && mode_ctl[MODE_HALF_IRQ_BIT]));
        end
    end

    // Status flags: hardware set wins over a software clear.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            half_complete_flag <= 1'b0;
            full_complete_flag <= 1'b0;
            cmp_hit_flag <= 1'b0;
        end else begin
            if (wr_hit && SFR_ADDR == ADDR_STATUS) begin
                half_complete_flag <= half_complete_flag & SFR_WDATA[STAT_HALF_BIT];
                full_complete_flag <= full_complete_flag & SFR_WDATA[STAT_FULL_BIT];
                cmp_hit_flag <= cmp_hit_flag & SFR_WDATA[STAT_CMP_HIT_BIT];
            end
            if (conv_end && half_hit) begin
                half_complete_flag <= 1'b1;
            end
            if (conv_end && run_last) begin
                full_complete_flag <= 1'b1;
            end
            if (conv_end && next_compare && !compare_output) begin
                cmp_hit_flag <= 1'b1;
            end
        end
    end

    // Register writes; the result registers take no writes.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_ctl <= REG_RESET[5:0];
            ctl_two <= REG_RESET;
            delay_low <= REG_RESET;
            sample_count <= REG_RESET;
            disable_a <= REG_RESET;
            disable_b <= REG_RESET[7:1];
            compare_threshold <= 12'h000;
        end else if (wr_hit) begin
            unique case (SFR_ADDR)
                ADDR_MODE_CTL: mode_ctl <= SFR_WDATA[5:0];
                ADDR_CTL_TWO: ctl_two <= SFR_WDATA;
                ADDR_DELAY_LOW: delay_low <= SFR_WDATA;
                ADDR_SAMPLE_COUNT: sample_count <= SFR_WDATA;
                ADDR_DISABLE_A: disable_a <= SFR_WDATA;
                ADDR_DISABLE_B: disable_b <= SFR_WDATA[7:1];
                ADDR_COMPARE_HIGH: compare_threshold[11:4] <= SFR_WDATA;
                ADDR_COMPARE_LOW: compare_threshold[3:0] <= SFR_WDATA[3:0];
                default: begin
                end
            endcase
        end
    end

    // Read data is registered one cycle after a read strobe.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            unique case (SFR_ADDR)
                ADDR_MODE_CTL: SFR_RDATA <= {2'b00, mode_ctl};
                ADDR_CTL_TWO: SFR_RDATA <= {ctl_two[7:5], compare_output, ctl_two[3:0]};
                ADDR_DELAY_LOW: SFR_RDATA <= delay_low;
                ADDR_SAMPLE_COUNT: SFR_RDATA <= sample_count;
                ADDR_STATUS: SFR_RDATA <= {5'h00, cmp_hit_flag, half_complete_flag,
                    full_complete_flag};
                ADDR_DISABLE_A: SFR_RDATA <= disable_a;
                ADDR_DISABLE_B: SFR_RDATA <= {disable_b, 1'b0};
                // result split, reserved bits read zero.
                ADDR_RESULT_HIGH: SFR_RDATA <= conversion_result[11:4];
                ADDR_RESULT_LOW: SFR_RDATA <= {4'h0, conversion_result[3:0]};
                ADDR_COMPARE_HIGH: SFR_RDATA <= compare_threshold[11:4];
                ADDR_COMPARE_LOW: SFR_RDATA <= {4'h0, compare_threshold[3:0]};
                default: SFR_RDATA <= 8'h00;
            endcase
        end
    end

    // Gated digital reads of the analog pins.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PIN_READ_A <= 8'h00;
            PIN_READ_B <= 8'h00;
        end else begin
            PIN_READ_A <= din_a_sync & ~disable_a;
            PIN_READ_B <= din_b_sync & ~{disable_b, 1'b0};
        end
    end

    // Static outputs from registers.
    always_comb begin
        COMPARE_OUT = compare_output;
        FAULT_BRAKE_EN = ctl_two[CTL2_BRAKE_BIT];
    end

    chk_single_irq: assert property (@(posedge REF_CLK) disable iff (RST)
        conv_end && !mode_ctl[MODE_REPEAT_BIT] |=> CONV_IRQ && full_complete_flag)
        else $error("single conversion did not raise interrupt");

    chk_run_quiet: assert property (@(posedge REF_CLK) disable iff (RST)
        conv_end && !run_last && !(half_hit && mode_ctl[MODE_HALF_IRQ_BIT]) |=> !CONV_IRQ)
        else $error("interrupt raised mid run");

    chk_half_irq: assert property (@(posedge REF_CLK) disable iff (RST)
        conv_end && half_hit |=> half_complete_flag
        && (CONV_IRQ == $past(mode_ctl[MODE_HALF_IRQ_BIT])))
        else $error("halfway interrupt wrong");

    chk_run_length: assert property (@(posedge REF_CLK) disable iff (RST)
        conv_end && mode_ctl[MODE_REPEAT_BIT] && run_last |-> done_count == {1'b0, sample_count})
        else $error("continuous run length wrong");

    chk_acq_entry: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_ACQUIRE && $past(state) != ST_ACQUIRE
        |-> timer == $past(acq_cycles) - 11'h001)
        else $error("acquisition length wrong");

    chk_conv_length: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_CONVERT && $past(state) == ST_ACQUIRE
        |-> timer == ($past(SLOW_MODE) ? SLOW_CONV_CYCLES : FAST_CONV_CYCLES) - 11'h001)
        else $error("conversion length wrong");

    chk_trig_delay: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_IDLE && !SW_START && ext_start && delay_count != 9'h000
        |=> state == ST_DELAY && timer == {2'b00, $past(delay_count)} - 11'h001)
        else $error("trigger delay not loaded");

    chk_busy_ignore: assert property (@(posedge REF_CLK) disable iff (RST)
        state == ST_ACQUIRE && timer != 11'h000
        |=> state == ST_ACQUIRE && timer == $past(timer) - 11'h001)
        else $error("busy sequencer disturbed");

    chk_result_pair: assert property (@(posedge REF_CLK) disable iff (RST)
        conv_end |=> conversion_result == $past(CONV_RESULT) ##1 $stable(conversion_result)
        || $past(conv_end))
        else $error("result not captured whole");

    chk_pin_gate: assert property (@(posedge REF_CLK) disable iff (RST)
        ##1 (PIN_READ_A & $past(disable_a)) == 8'h00)
        else $error("disabled pin read nonzero");

endmodule
`default_nettype wire

// ==== core/adc_seq_pkg.sv ====
/*
 * Constants for the converter sequencing control: register addresses,
 * field positions, reset values and timing counts.
 * Assumes a 250 MHz converter clock and a byte-wide register port.
 */
// Summary of operation
// - Half-done enable raises interrupt at halfway point.
// - Single mode interrupts after every conversion.
// - Continuous mode interrupts after whole run.
// - Upper channels sample four times field plus six.
// - Speed bit selects 1400ns or 4750ns conversion.
// - Either speed bit selects slow mode.
// - Delay count is nine bits, ninth elsewhere.
// - External trigger waits delay count before converting.
// - Delay applies only with external trigger enabled.
// - First disable register forces pin reads zero.
// - Second disable register bits seven..one likewise.
// - Result split high byte, low nibble, read-only.
// - Compare threshold split high byte, low nibble.
// - Comparator output follows polarity bit.
// - Busy converter ignores further external triggers.
// - Continuous run counts sample setting plus one.
// - Half-complete flag set by hardware, cleared writing zero.
package adc_seq_pkg;

    // Register addresses on the byte-wide register port.
    localparam logic [7:0] ADDR_MODE_CTL = 8'h86;
    localparam logic [7:0] ADDR_SAMPLE_COUNT = 8'h8D;
    localparam logic [7:0] ADDR_STATUS = 8'h8F;
    localparam logic [7:0] ADDR_DISABLE_B = 8'h99;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hC2;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hC3;
    localparam logic [7:0] ADDR_COMPARE_LOW = 8'hCE;
    localparam logic [7:0] ADDR_COMPARE_HIGH = 8'hCF;
    localparam logic [7:0] ADDR_CTL_TWO = 8'hE2;
    localparam logic [7:0] ADDR_DELAY_LOW = 8'hE3;
    localparam logic [7:0] ADDR_DISABLE_A = 8'hF6;

    // Reset value shared by every register of the block.
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions in the sampling mode control register.
    localparam int MODE_HALF_IRQ_BIT = 5;
    localparam int MODE_REPEAT_BIT = 4;
    localparam int MODE_ACQ_MSB = 3;
    localparam int MODE_ACQ_LSB = 1;
    localparam int MODE_SLOW_BIT = 0;

    // Field positions in converter control two.
    localparam int CTL2_BRAKE_BIT = 7;
    localparam int CTL2_POLARITY_BIT = 6;
    localparam int CTL2_CMP_EN_BIT = 5;
    localparam int CTL2_CMP_OUT_BIT = 4;
    localparam int CTL2_ACQ_MSB = 3;
    localparam int CTL2_ACQ_LSB = 1;
    localparam int CTL2_DELAY8_BIT = 0;

    // Field positions in the status register.
    localparam int STAT_CMP_HIT_BIT = 2;
    localparam int STAT_HALF_BIT = 1;
    localparam int STAT_FULL_BIT = 0;

    // First channel number that uses the upper acquisition field.
    localparam logic [3:0] UPPER_CHANNEL_FIRST = 4'h9;

    // Acquisition time is step times field plus base, in clock cycles.
    localparam logic [10:0] ACQ_BASE_CYCLES = 11'h006;

    // Clock period and conversion times in nanoseconds.
    localparam int CLK_PERIOD_NS = 4;
    localparam int FAST_CONV_NS = 1400;
    localparam int SLOW_CONV_NS = 4750;

    // Conversion times as least cycle counts, rounded up.
    localparam logic [10:0] FAST_CONV_CYCLES =
        11'((FAST_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [10:0] SLOW_CONV_CYCLES =
        11'((SLOW_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ACQUIRE, ST_CONVERT} seq_state_e;

endpackage

// ==== core/adc_pin_sync.sv ====
/*
 * Two-flip-flop synchroniser for a group of levels from outside the clock.
 * Assumes the inputs are slow levels; only the second stage is read out.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);

    // First stage, read only by the second stage.
    logic [WIDTH-1:0] meta_stage;

    // Both stages clear on reset and shift every edge.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            meta_stage <= '0;
            SYNC_OUT <= '0;
        end else begin
            meta_stage <= ASYNC_IN;
            SYNC_OUT <= meta_stage;
        end
    end

endmodule
`default_nettype wire

// ==== tb/adc_core_model.sv ====
/*
 * Stand-in for the analog converter core that feeds the sequencer.
 * Assumes the sequencer samples the result in its last convert cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic CONVERT_EN,
    input wire logic [11:0] VALUE,
    output logic [11:0] CONV_RESULT
);
    // Outside a conversion the value is stale, so the inverse is shown.
    assign CONV_RESULT = CONVERT_EN ? VALUE : ~VALUE;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the converter sequencing control.
 * Assumes a 250 MHz clock; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, din_a = 8'h00, din_b = 8'h00, rd_a, rd_b;
    logic wr = 1'b0, rd = 1'b0, start = 1'b0, trig_en = 1'b0, trig = 1'b0, aux = 1'b0;
    logic [3:0] chan = 4'h0;
    logic [11:0] value = 12'h000, res;
    logic smp, cnv, slow, busy, irq, cmp;
    int err_count = 0, total_checks = 0, cyc = 0;
    logic [7:0] regs [8] = '{ADDR_MODE_CTL, ADDR_DISABLE_B, ADDR_RESULT_LOW, ADDR_RESULT_HIGH,
        ADDR_COMPARE_LOW, ADDR_COMPARE_HIGH, ADDR_DELAY_LOW, ADDR_DISABLE_A};
    // Clock at 4 ns period.
    always #2 clk = ~clk;
    adc_seq_ctrl i_dut (.REF_CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SW_START(start),
        .EXT_TRIG_EN(trig_en), .EXT_TRIG(trig), .AUX_SLOW(aux), .CHANNEL(chan),
        .CONV_RESULT(res), .SAMPLE_EN(smp), .CONVERT_EN(cnv), .SLOW_MODE(slow),
        .BUSY(busy), .CONV_IRQ(irq), .COMPARE_OUT(cmp), .FAULT_BRAKE_EN(),
        .PIN_DIN_A(din_a), .PIN_DIN_B(din_b), .PIN_READ_A(rd_a), .PIN_READ_B(rd_b));
    adc_core_model i_core (.CONVERT_EN(cnv), .VALUE(value), .CONV_RESULT(res));
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cut a hang short well past the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("register", {4'h0, exp}, {4'h0, rdata});
    endtask
    // One start, then count delay, sampling, converting and interrupt cycles.
    task automatic run(input bit ext, input int dly, input int ns, input int nc, input int ni);
        int d, s, c, q, n;
        d = 0; s = 0; c = 0; q = 0; n = 0;
        @(negedge clk);
        trig = 1'b0;
        start = !ext;
        @(negedge clk);
        start = 1'b0;
        trig = ext;
        // A software start is already sampling here, so count this cycle too.
        if (smp === 1'b1) s++;
        while ((busy !== 1'b0 || n < 8) && n < 6000) begin
            @(negedge clk);
            n++;
            // A second trigger edge while busy must be ignored.
            if (n == 100) trig = 1'b0;
            if (n == 110) trig = 1'b1;
            if (busy === 1'b1 && smp === 1'b0 && cnv === 1'b0) d++;
            if (smp === 1'b1) s++;
            if (cnv === 1'b1) c++;
            if (irq === 1'b1) q++;
        end
        if (dly >= 0) chk("delay cycles", 12'(dly), 12'(d));
        chk("sample cycles", 12'(ns), 12'(s));
        chk("convert cycles", 12'(nc), 12'(c));
        chk("interrupts", 12'(ni), 12'(q));
    endtask
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (regs[i]) rd_reg(regs[i], REG_RESET);
        rd_reg(8'h80, 8'h00);
        wr_reg(ADDR_COMPARE_HIGH, 8'hAB);
        wr_reg(ADDR_COMPARE_LOW, 8'h0C);
        wr_reg(ADDR_RESULT_HIGH, 8'h55);
        rd_reg(ADDR_COMPARE_HIGH, 8'hAB);
        rd_reg(ADDR_COMPARE_LOW, 8'h0C);
        rd_reg(ADDR_RESULT_HIGH, 8'h00);
        value = 12'hABD;
        run(1'b0, 0, 6, 350, 1);
        rd_reg(ADDR_RESULT_HIGH, 8'hAB);
        rd_reg(ADDR_RESULT_LOW, 8'h0D);
        chk("compare out", 12'h001, {11'h000, cmp});
        // Upper channel, field one, slow through the auxiliary bit.
        chan = 4'h9;
        aux = 1'b1;
        value = 12'h123;
        wr_reg(ADDR_MODE_CTL, 8'h02);
        run(1'b0, 0, 10, 1188, 1);
        chk("compare out", 12'h000, {11'h000, cmp});
        aux = 1'b0;
        wr_reg(ADDR_MODE_CTL, 8'h01);
        chk("slow mode", 12'h001, {11'h000, slow});
        wr_reg(ADDR_MODE_CTL, 8'h00);
        chan = 4'h0;
        // Polarity set: a result below the threshold now reads one.
        wr_reg(ADDR_CTL_TWO, 8'h41);
        wr_reg(ADDR_DELAY_LOW, 8'h02);
        run(1'b0, 0, 6, 350, 1);
        chk("compare out", 12'h001, {11'h000, cmp});
        trig_en = 1'b1;
        run(1'b1, 258, 6, 350, 1);
        trig_en = 1'b0;
        wr_reg(ADDR_STATUS, 8'h00);
        wr_reg(ADDR_SAMPLE_COUNT, 8'h03);
        wr_reg(ADDR_MODE_CTL, 8'h30);
        run(1'b0, -1, 24, 1400, 2);
        rd_reg(ADDR_STATUS, 8'h03);
        wr_reg(ADDR_STATUS, 8'h00);
        rd_reg(ADDR_STATUS, 8'h00);
        // Halfway interrupt off: only the end of the run interrupts.
        wr_reg(ADDR_MODE_CTL, 8'h10);
        run(1'b0, 0, 24, 1400, 1);
        rd_reg(ADDR_STATUS, 8'h03);
        din_a = 8'hFF;
        din_b = 8'hFF;
        wr_reg(ADDR_DISABLE_A, 8'h0F);
        wr_reg(ADDR_DISABLE_B, 8'hF1);
        repeat (5) @(negedge clk);
        chk("pin read a", 12'h0F0, {4'h0, rd_a});
        chk("pin read b", 12'h00F, {4'h0, rd_b});
        end_sim();
    end
endmodule
`default_nettype wire
